// file: inc/srl_cfg.svh
// Purpose: Offsets, field positions and timing counts of the serial ROM config loader
// Assumes: 200 MHz core clock, 1 MHz serial clock
// Notes: Definitions only
`ifndef SRL_CFG_SVH
`define SRL_CFG_SVH

// Register offsets in the internal register space
`define SRL_OFS_CMD 9'h040
`define SRL_OFS_DATA 9'h042

// Command register fields
`define SRL_CMD_EXT_BIT 10
`define SRL_OP_READ 2'h2
`define SRL_OP_WRITE 2'h1
`define SRL_OP_ERASE 2'h3
`define SRL_OP_SPECIAL 2'h0
`define SRL_SUB_EWEN 2'h3
`define SRL_SUB_EWDS 2'h0
`define SRL_SUB_ERAL 2'h2
`define SRL_SUB_WRAL 2'h1

// Self-status bit positions
`define SRL_ST_CHKOK_BIT 10
`define SRL_ST_BUSY_BIT 8
`define SRL_ST_INIT_DONE_FLAG_BIT 7

// Block layout
`define SRL_NO_DATA_WORD 16'hFFFF
`define SRL_REG_STEP 9'h002
`define SRL_PROBE_EDGE 10

// Boot ROM decode ignores the low twelve mask bits
`define SRL_BOOT_MASK_USE 20'hFF000

// Timing
`define SRL_CLK_PERIOD_NS 5
`define SRL_SK_PERIOD_NS 1000
`define SRL_SK_HALF_CYC ((`SRL_SK_PERIOD_NS / 2 + `SRL_CLK_PERIOD_NS - 1) / `SRL_CLK_PERIOD_NS)
`define SRL_WRITE_TIME_NS 10000000
`define SRL_WRITE_TIMEOUT_CYC (`SRL_WRITE_TIME_NS / `SRL_CLK_PERIOD_NS)
`define SRL_STRAP_WAIT_CYC 3

`endif

// file: inc/srl_pkg.sv
// Purpose: Types shared by the serial ROM config loader
// Assumes: Nothing beyond the config header
// Notes: Offsets live in srl_cfg.svh
package srl_pkg;

  // Loader and command sequencer states
  typedef enum logic [3:0] {
    ST_START = 4'h0,
    ST_GAP = 4'h1,
    ST_PROBE = 4'h2,
    ST_RDWORD = 4'h3,
    ST_LOAD = 4'h4,
    ST_CHECK = 4'h5,
    ST_DONE = 4'h6,
    ST_READY = 4'h7,
    ST_CMD = 4'h8,
    ST_RDY_GAP = 4'h9,
    ST_RDY_WAIT = 4'hA
  } srl_state_e;

  // Host access to the internal register space
  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [15:0] wdata;
  } srl_host_req_s;

  // One configuration word bound for an internal register
  typedef struct packed {
    logic valid;
    logic [8:0] addr;
    logic [15:0] data;
  } srl_cfg_wr_s;

endpackage : srl_pkg

// file: src/srl_loader.sv
// Purpose: Serial ROM configuration loader and host command engine
// Assumes: Host port and boot decode inputs are on the core clock; rom_serial_in is asynchronous
// Notes: Config words leave on cfg_wr; a bad checksum pulses cfg_restore for a partial reset
`timescale 1ns/100ps
`include "srl_cfg.svh"
module srl_loader
  import srl_pkg::*;
#(
  parameter int unsigned WRITE_TIMEOUT_CYC = `SRL_WRITE_TIMEOUT_CYC
) (
  input wire logic clock, // Core clock, 200 MHz
  input wire logic nrst, // Synchronous reset, active low
  input wire srl_host_req_s host_req, // Host register access
  output logic [15:0] host_rdata, // Registered read data
  output logic [15:0] self_status, // Self-status word
  output srl_cfg_wr_s cfg_wr, // Config word to internal register
  output logic cfg_restore, // Pulse: restore defaults
  input wire logic rom_serial_in, // Serial data from memory
  output logic rom_serial_out, // Serial data to memory
  output logic rom_serial_clock, // 1 MHz serial clock
  output logic rom_chip_select, // Memory chip select
  output logic ext_logic_select_pin, // External logic select
  input wire logic mem_rd, // Host memory-space read
  input wire logic [19:0] mem_addr, // Host memory address
  input wire logic [19:0] boot_base, // Boot ROM base address
  input wire logic [19:0] boot_mask, // Boot ROM address mask
  output logic boot_rom_select_n // Boot ROM select, active low
);

  if (WRITE_TIMEOUT_CYC < 1 || WRITE_TIMEOUT_CYC >= (1 << 22)) begin : g_bad
    $error("srl_loader: WRITE_TIMEOUT_CYC out of range");
  end

  srl_state_e state_q;
  logic din_m_q, din_s_q;
  logic wide_q, sel_q, ext_target_q;
  logic busy_q, init_done_q, chk_ok_q, restore_q;
  logic [7:0] rd_addr_q, chk_addr_q, sum_q;
  logic [4:0] grp_left_q;
  logic [8:0] reg_addr_q;
  logic [21:0] gap_q;
  logic [15:0] cmd_q, data_q, rdata_q;
  srl_cfg_wr_s cfg_q;
  logic sh_start_q, sh_done, sh_probe, sh_sk, sh_dout;
  logic [26:0] sh_tx_q;
  logic [4:0] sh_nout_q, sh_nin_q;
  logic [15:0] sh_rx;
  logic boot_sel_n_q;
  logic [1:0] op, sub;
  logic cmd_data, cmd_read, cmd_wait, cmd_wr, gap_end;
  logic [7:0] word_sum;

  // Two flops before anything looks at the serial input pin
  always_ff @(posedge clock) begin
    if (!nrst) begin
      din_m_q <= 1'b0;
      din_s_q <= 1'b0;
    end else begin
      din_m_q <= rom_serial_in;
      din_s_q <= din_m_q;
    end
  end

  srl_shifter #(
    .HALF_CYC(`SRL_SK_HALF_CYC),
    .PROBE_EDGE(`SRL_PROBE_EDGE)
  ) u_shift (
    .clock(clock),
    .nrst(nrst),
    .start(sh_start_q),
    .tx(sh_tx_q),
    .n_out(sh_nout_q),
    .n_in(sh_nin_q),
    .din(din_s_q),
    .sk(sh_sk),
    .dout(sh_dout),
    .done(sh_done),
    .rx(sh_rx),
    .probe(sh_probe)
  );

  // Command decode from the stored command word
  assign op = cmd_q[9:8];
  assign sub = wide_q ? cmd_q[7:6] : cmd_q[5:4];
  assign cmd_read = (op == `SRL_OP_READ);
  assign cmd_data = (op == `SRL_OP_WRITE) || (op == `SRL_OP_SPECIAL && sub == `SRL_SUB_WRAL);
  // Erase, erase-all and both writes program cells, so they need a ready wait
  assign cmd_wait = (op == `SRL_OP_WRITE) || (op == `SRL_OP_ERASE) ||
    (op == `SRL_OP_SPECIAL && (sub == `SRL_SUB_ERAL || sub == `SRL_SUB_WRAL));
  assign cmd_wr = host_req.wr && host_req.addr == `SRL_OFS_CMD;
  assign gap_end = (gap_q == 22'(`SRL_SK_HALF_CYC - 1));
  assign word_sum = sh_rx[15:8] + sh_rx[7:0];

  // Sequencer: strap, probe, block readout, check, then host commands
  always_ff @(posedge clock) begin
    sh_start_q <= 1'b0;
    restore_q <= 1'b0;
    cfg_q.valid <= 1'b0;
    if (!nrst) begin
      state_q <= ST_START;
      gap_q <= 22'h000000;
      sel_q <= 1'b0;
      ext_target_q <= 1'b0;
      wide_q <= 1'b0;
      busy_q <= 1'b1;
      init_done_q <= 1'b0;
      chk_ok_q <= 1'b0;
      rd_addr_q <= 8'h00;
      chk_addr_q <= 8'h00;
      sum_q <= 8'h00;
      grp_left_q <= 5'h00;
      reg_addr_q <= 9'h000;
      cmd_q <= 16'h0000;
      sh_tx_q <= '0;
      sh_nout_q <= 5'h00;
      sh_nin_q <= 5'h00;
      cfg_q.addr <= 9'h000;
      cfg_q.data <= 16'h0000;
    end else begin
      case (state_q)
        ST_START: begin
          gap_q <= gap_q + 22'h000001;
          if (gap_q == 22'(`SRL_STRAP_WAIT_CYC)) begin
            gap_q <= 22'h000000;
            if (din_s_q) begin
              // Probe read of word zero with eight address bits
              state_q <= ST_PROBE;
              sel_q <= 1'b1;
              sh_start_q <= 1'b1;
              sh_tx_q <= {1'b1, `SRL_OP_READ, 8'h00, 16'h0000};
              sh_nout_q <= 5'd11;
              sh_nin_q <= 5'h00;
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_PROBE: if (sh_done) begin
          wide_q <= sh_probe;
          sel_q <= 1'b0;
          state_q <= ST_GAP;
        end
        ST_GAP: begin
          // Chip select stays low for half a serial period between words
          gap_q <= gap_q + 22'h000001;
          if (gap_end) begin
            gap_q <= 22'h000000;
            state_q <= ST_RDWORD;
            sel_q <= 1'b1;
            sh_start_q <= 1'b1;
            sh_nin_q <= 5'd17; // Leading dummy zero falls out of the top of rx
            sh_tx_q <= wide_q ? {1'b1, `SRL_OP_READ, rd_addr_q, 16'h0000} :
              {1'b1, `SRL_OP_READ, rd_addr_q[5:0], 18'h00000};
            sh_nout_q <= wide_q ? 5'd11 : 5'd9;
          end
        end
        ST_RDWORD: if (sh_done) begin
          sel_q <= 1'b0;
          state_q <= ST_LOAD;
        end
        ST_LOAD: begin
          rd_addr_q <= rd_addr_q + 8'h01;
          state_q <= ST_GAP;
          if (rd_addr_q == 8'h00) begin
            if (sh_rx == `SRL_NO_DATA_WORD) begin
              state_q <= ST_DONE;
            end else begin
              chk_addr_q <= {1'b0, sh_rx[7:1]};
              sum_q <= word_sum;
              grp_left_q <= 5'h00;
            end
          end else if (rd_addr_q == chk_addr_q) begin
            sum_q <= sum_q + sh_rx[15:8];
            state_q <= ST_CHECK;
          end else if (sh_rx == `SRL_NO_DATA_WORD) begin
            state_q <= ST_CHECK;
          end else begin
            sum_q <= sum_q + word_sum;
            if (grp_left_q == 5'h00) begin
              grp_left_q <= {1'b0, sh_rx[15:12]} + 5'h01;
              reg_addr_q <= sh_rx[8:0];
            end else begin
              cfg_q.valid <= 1'b1;
              cfg_q.addr <= reg_addr_q;
              cfg_q.data <= sh_rx;
              reg_addr_q <= reg_addr_q + `SRL_REG_STEP;
              grp_left_q <= grp_left_q - 5'h01;
            end
          end
        end
        ST_CHECK: begin
          chk_ok_q <= (sum_q == 8'h00);
          restore_q <= (sum_q != 8'h00);
          state_q <= ST_DONE;
        end
        ST_DONE: begin
          init_done_q <= 1'b1;
          busy_q <= 1'b0;
          state_q <= ST_READY;
        end
        ST_READY: if (cmd_wr) begin
          // A command written while busy is dropped; the host must poll first
          cmd_q <= host_req.wdata;
          ext_target_q <= host_req.wdata[`SRL_CMD_EXT_BIT];
          busy_q <= 1'b1;
          sel_q <= 1'b1;
          sh_start_q <= 1'b1;
          state_q <= ST_CMD;
          // Opcode, address, then data for the two write forms
          sh_tx_q <= wide_q ? {1'b1, host_req.wdata[9:0], data_q} :
            {1'b1, host_req.wdata[9:8], host_req.wdata[5:0], data_q, 2'h0};
          sh_nin_q <= (host_req.wdata[9:8] == `SRL_OP_READ) ? 5'd17 : 5'd0;
          if ((host_req.wdata[9:8] == `SRL_OP_WRITE) || (host_req.wdata[9:8] == `SRL_OP_SPECIAL &&
              (wide_q ? host_req.wdata[7:6] : host_req.wdata[5:4]) == `SRL_SUB_WRAL)) begin
            sh_nout_q <= wide_q ? 5'd27 : 5'd25;
          end else begin
            sh_nout_q <= wide_q ? 5'd11 : 5'd9;
          end
        end
        ST_CMD: if (sh_done) begin
          sel_q <= 1'b0;
          gap_q <= 22'h000000;
          if (cmd_wait) begin
            state_q <= ST_RDY_GAP;
          end else begin
            busy_q <= 1'b0;
            state_q <= ST_READY;
          end
        end
        ST_RDY_GAP: begin
          gap_q <= gap_q + 22'h000001;
          if (gap_end) begin
            gap_q <= 22'h000000;
            sel_q <= 1'b1;
            state_q <= ST_RDY_WAIT;
          end
        end
        ST_RDY_WAIT: begin
          // Memory raises its output when programming ends; the first two samples still hold the pull-up level
          gap_q <= gap_q + 22'h000001;
          if ((din_s_q && gap_q >= 22'h000002) || gap_q == 22'(WRITE_TIMEOUT_CYC)) begin
            sel_q <= 1'b0;
            busy_q <= 1'b0;
            state_q <= ST_READY;
          end
        end
        default: state_q <= ST_START;
      endcase
    end
  end

  // Data register: host writes when idle, a read command fills it
  always_ff @(posedge clock) begin
    if (!nrst) begin
      data_q <= 16'h0000;
    end else if (state_q == ST_CMD && sh_done && cmd_read) begin
      data_q <= sh_rx;
    end else if (!busy_q && host_req.wr && host_req.addr == `SRL_OFS_DATA) begin
      data_q <= host_req.wdata;
    end
  end

  // Registered host read port
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_q <= 16'h0000;
    end else if (host_req.rd) begin
      rdata_q <= (host_req.addr == `SRL_OFS_CMD) ? cmd_q :
        (host_req.addr == `SRL_OFS_DATA) ? data_q : 16'h0000;
    end
  end

  // Boot ROM window decode in 4-kilobyte granules
  always_ff @(posedge clock) begin
    if (!nrst) begin
      boot_sel_n_q <= 1'b1;
    end else begin
      boot_sel_n_q <= !(mem_rd && ((mem_addr ^ boot_base) & boot_mask & `SRL_BOOT_MASK_USE) == 20'h00000);
    end
  end

  always_comb begin
    self_status = 16'h0000;
    self_status[`SRL_ST_CHKOK_BIT] = chk_ok_q;
    self_status[`SRL_ST_BUSY_BIT] = busy_q;
    self_status[`SRL_ST_INIT_DONE_FLAG_BIT] = init_done_q;
  end

  assign host_rdata = rdata_q;
  assign cfg_wr = cfg_q;
  assign cfg_restore = restore_q;
  assign rom_serial_out = sh_dout;
  assign rom_serial_clock = sh_sk;
  assign rom_chip_select = sel_q && !ext_target_q;
  assign ext_logic_select_pin = sel_q && ext_target_q;
  assign boot_rom_select_n = boot_sel_n_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  strap_skip_a: assert property ((state_q == ST_START && gap_q == 22'(`SRL_STRAP_WAIT_CYC) && !din_s_q) |=>
    (state_q == ST_DONE && !rom_chip_select)) else $error("strap low still started a readout");
  first_read_a: assert property ((state_q == ST_START && gap_q == 22'(`SRL_STRAP_WAIT_CYC) && din_s_q) |=>
    (rom_chip_select && sh_tx_q[26:16] == 11'h600)) else $error("first word read not issued at word zero");
  size_pick_a: assert property ((state_q == ST_PROBE && sh_done) |=> (wide_q == $past(sh_probe)))
    else $error("address width not taken from probe edge");
  end_marker_a: assert property ((state_q == ST_LOAD && rd_addr_q != 8'h00 && rd_addr_q != chk_addr_q &&
    sh_rx == `SRL_NO_DATA_WORD) |=> (state_q == ST_CHECK && !cfg_wr.valid)) else $error("all-ones word did not end load");
  group_load_a: assert property ((state_q == ST_LOAD && rd_addr_q != 8'h00 && rd_addr_q != chk_addr_q &&
    sh_rx != `SRL_NO_DATA_WORD && grp_left_q != 5'h00) |=> (cfg_wr.valid && cfg_wr.addr == $past(reg_addr_q)
    && reg_addr_q == $past(reg_addr_q) + `SRL_REG_STEP)) else $error("group word not stored at next register");
  chk_bad_a: assert property ((state_q == ST_CHECK && sum_q != 8'h00) |=>
    (cfg_restore && !self_status[`SRL_ST_CHKOK_BIT]) ##1 !cfg_restore) else $error("bad checksum did not restore");
  chk_good_a: assert property ((state_q == ST_CHECK && sum_q == 8'h00) |=>
    (self_status[`SRL_ST_CHKOK_BIT] && !cfg_restore)) else $error("good checksum flag not set");
  init_flag_a: assert property ((state_q == ST_DONE) |=>
    (self_status[`SRL_ST_INIT_DONE_FLAG_BIT] && !self_status[`SRL_ST_BUSY_BIT])) else $error("init done not reported");
  cmd_take_a: assert property ((state_q == ST_READY && cmd_wr) |=>
    (state_q == ST_CMD && self_status[`SRL_ST_BUSY_BIT] && cmd_q == $past(host_req.wdata))) else $error("command not taken");
  target_sel_a: assert property (!(rom_chip_select && ext_logic_select_pin))
    else $error("both select outputs active");
  read_back_a: assert property ((state_q == ST_CMD && sh_done && cmd_read) |=> (data_q == $past(sh_rx)))
    else $error("read data not placed in data register");
  boot_sel_a: assert property ((mem_rd && ((mem_addr ^ boot_base) & boot_mask & `SRL_BOOT_MASK_USE) == 20'h00000)
    |=> !boot_rom_select_n) else $error("boot window read did not select");

  cov_strap_low_c: cover property (state_q == ST_START ##1 state_q == ST_DONE);
  cov_load_ok_c: cover property (state_q == ST_CHECK && sum_q == 8'h00);
  cov_load_bad_c: cover property (cfg_restore);
  cov_cmd_read_c: cover property (state_q == ST_CMD && sh_done && cmd_read);

endmodule : srl_loader

// file: src/srl_shifter.sv
// Purpose: Three-wire serial shift engine with a divided serial clock
// Assumes: din already synchronised; tx left-justified, msb first
// Notes: Bits change while the serial clock is low and are sampled on its rising edge
`timescale 1ns/100ps
`include "srl_cfg.svh"
module srl_shifter
  import srl_pkg::*;
#(
  parameter int HALF_CYC = `SRL_SK_HALF_CYC,
  parameter int PROBE_EDGE = `SRL_PROBE_EDGE
) (
  input wire logic clock, // Core clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic start, // One-cycle start pulse
  input wire logic [26:0] tx, // Bits to send, left-justified
  input wire logic [4:0] n_out, // Number of bits to send
  input wire logic [4:0] n_in, // Number of bits to receive
  input wire logic din, // Synchronised serial input
  output logic sk, // Serial clock
  output logic dout, // Serial output bit
  output logic done, // One-cycle end pulse
  output logic [15:0] rx, // Received word
  output logic probe // Input seen on the probe edge
);

  if (HALF_CYC < 1 || PROBE_EDGE < 1 || PROBE_EDGE > 31) begin : g_bad
    $error("srl_shifter: unsupported parameter value");
  end

  logic run_q;
  logic sk_q;
  logic done_q;
  logic probe_q;
  logic [26:0] tx_q;
  logic [4:0] out_q;
  logic [4:0] in_q;
  logic [4:0] edge_q;
  logic [15:0] rx_q;
  logic [$clog2(HALF_CYC + 1)-1:0] div_q;
  logic tick;

  // One enable pulse per serial half period
  assign tick = run_q && (div_q == ($clog2(HALF_CYC + 1))'(HALF_CYC - 1));

  always_ff @(posedge clock) begin
    if (!nrst || !run_q || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // Clock phase, edge count and end of transfer
  always_ff @(posedge clock) begin
    done_q <= 1'b0;
    if (!nrst) begin
      run_q <= 1'b0;
      sk_q <= 1'b0;
      edge_q <= 5'h00;
    end else if (start) begin
      run_q <= 1'b1;
      sk_q <= 1'b0;
      edge_q <= 5'h00;
    end else if (tick && !sk_q) begin
      sk_q <= 1'b1;
      edge_q <= edge_q + 5'h01;
    end else if (tick) begin
      sk_q <= 1'b0;
      if (out_q <= 5'h01 && in_q == 5'h00) begin
        run_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  // Outgoing bits advance on the falling edge
  always_ff @(posedge clock) begin
    if (!nrst) begin
      tx_q <= '0;
      out_q <= 5'h00;
    end else if (start) begin
      tx_q <= tx;
      out_q <= n_out;
    end else if (tick && sk_q) begin
      tx_q <= tx_q << 1;
      if (out_q != 5'h00) begin
        out_q <= out_q - 5'h01;
      end
    end
  end

  // Incoming bits and the probe bit are taken on the rising edge
  always_ff @(posedge clock) begin
    if (!nrst) begin
      in_q <= 5'h00;
      rx_q <= 16'h0000;
      probe_q <= 1'b0;
    end else if (start) begin
      in_q <= n_in;
    end else if (tick && !sk_q) begin
      if (edge_q + 5'h01 == 5'(PROBE_EDGE)) begin
        probe_q <= din;
      end
      if (out_q == 5'h00 && in_q != 5'h00) begin
        rx_q <= {rx_q[14:0], din};
        in_q <= in_q - 5'h01;
      end
    end
  end

  assign sk = sk_q;
  assign dout = tx_q[26];
  assign done = done_q;
  assign rx = rx_q;
  assign probe = probe_q;

endmodule : srl_shifter

// file: verif/srl_loader_test.sv
// Purpose: Self-checking bench for the serial ROM config loader
// Assumes: Memory model with 8-bit addresses, write timeout shortened
// Notes: Config blocks are kept small since every word costs 28 serial periods
`timescale 1ns/100ps
`include "srl_cfg.svh"
module srl_loader_test
  import srl_pkg::*;
();
  logic clock, nrst, strap_lo, mem_rd, sel_n, mdo, din, sdo, sck, cs, ext, restore;
  logic ext_seen = 1'b0;
  srl_host_req_s host_req;
  srl_cfg_wr_s cfg_wr;
  logic [15:0] rdata, status;
  logic [19:0] mem_addr, boot_base, boot_mask;
  logic [31:0] seed = 32'hAF3F00FF;
  logic [24:0] cq [$];
  int miscompares = 0;
  int n_compared = 0;
  int n_restore = 0;
  srl_loader #(.WRITE_TIMEOUT_CYC(2000)) dut (.clock(clock), .nrst(nrst), .host_req(host_req),
    .host_rdata(rdata), .self_status(status), .cfg_wr(cfg_wr), .cfg_restore(restore), .rom_serial_in(din),
    .rom_serial_out(sdo), .rom_serial_clock(sck), .rom_chip_select(cs), .ext_logic_select_pin(ext),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .boot_base(boot_base), .boot_mask(boot_mask), .boot_rom_select_n(sel_n));
  srl_rom_model rom (.cs(cs), .sk(sck), .di(sdo), .dout(mdo));
  // Strap pulls the data line low only around reset release
  assign din = mdo & !strap_lo;
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Collect config words, restore pulses and external selects
  always @(posedge clock) begin
    if (cfg_wr.valid) cq.push_back({cfg_wr.addr, cfg_wr.data});
    if (restore) n_restore++;
    if (ext) ext_seen = 1'b1;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task chk(input string what, input logic [24:0] exp, input logic [24:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task end_of_test();
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task do_reset(input logic strap);
    cq = {};
    n_restore = 0;
    nrst <= 1'b0;
    strap_lo <= !strap;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    repeat (8) @(posedge clock);
    strap_lo <= 1'b0;
  endtask : do_reset
  // Bounded poll of the busy flag; a hang counts as a mismatch
  task wait_idle();
    int i;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (status[8] !== 1'b0 && i < 60000);
    chk("busy", 25'h0, status[8]);
  endtask : wait_idle
  task wr(input logic [8:0] a, input logic [15:0] d);
    host_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    host_req <= '0;
  endtask : wr
  task rd_data(output logic [15:0] v);
    host_req <= '{wr: 1'b0, rd: 1'b1, addr: `SRL_OFS_DATA, wdata: 16'h0000};
    @(posedge clock);
    host_req <= '0;
    @(posedge clock);
    #1 v = rdata;
  endtask : rd_data
  task cmd(input logic [15:0] c);
    wait_idle();
    wr(`SRL_OFS_CMD, c);
    wait_idle();
  endtask : cmd
  // One group of two words; junk in the forced bits, checksum optionally broken
  task init_run(input logic bad);
    logic [15:0] w [5];
    logic [7:0] s;
    logic [31:0] r;
    r = rnd();
    w[0] = {r[15:8], 8'h08};
    w[1] = {4'h1, 3'h5, r[24:16]};
    r = rnd();
    w[2] = r[15:0];
    w[3] = r[31:16];
    s = 8'h00;
    for (int i = 0; i < 4; i++) s += w[i][15:8] + w[i][7:0];
    w[4] = {8'h00 - s + {7'h00, bad}, 8'h00};
    for (int i = 0; i < 5; i++) rom.mem[i] = w[i];
    do_reset(1'b1);
    wait_idle();
    chk("loaded", 25'h2, 25'(cq.size()));
    for (int i = 0; i < 2; i++) chk("cfg", {w[1][8:0] + 9'(2 * i), w[2 + i]}, cq[i]);
    chk("restore", bad, 25'(n_restore));
    chk("status", {!bad, 10'h080}, status);
  endtask : init_run
  initial begin
    repeat (110000) @(posedge clock);
    miscompares++;
    end_of_test();
  end
  initial begin
    logic [31:0] r;
    logic [15:0] v;
    logic [19:0] b, m, h, a;
    {nrst, strap_lo, mem_rd, host_req, mem_addr, boot_base, boot_mask} = '0;
    init_run(1'b1);
    do_reset(1'b0);
    wait_idle();
    chk("no readout", 25'h0000080, {9'(cq.size()), status});
    init_run(1'b0);
    cmd(16'h00C0);
    r = rnd();
    wr(`SRL_OFS_DATA, r[31:16]);
    cmd(16'h0040);
    chk("wral", r[31:16], rom.mem[8'hFF]);
    wr(`SRL_OFS_DATA, r[15:0]);
    cmd({8'h01, r[23:16]});
    chk("write", r[15:0], rom.mem[r[23:16]]);
    cmd({8'h02, r[23:16]});
    rd_data(v);
    chk("read", r[15:0], v);
    cmd({8'h06, r[23:16]});
    rd_data(v);
    chk("ext read", {1'b1, 16'hFFFF}, {ext_seen, v});
    cmd({8'h03, r[23:16]});
    chk("erase", 16'hFFFF, rom.mem[r[23:16]]);
    chk("kept", r[31:16], rom.mem[r[23:16] ^ 8'h01]);
    cmd(16'h0080);
    chk("eral", 16'hFFFF, rom.mem[8'h00]);
    cmd(16'h0000);
    // Erased memory reads all ones at word zero: no configuration, no restore
    do_reset(1'b1);
    wait_idle();
    chk("blank rom", 25'h0000080, {9'(cq.size() + n_restore), status});
    // Window hits and misses with random low mask bits
    for (int i = 0; i < 24; i++) begin
      @(posedge clock);
      r = rnd();
      b = {r[31:24], 12'h000};
      m = {4'hF, r[23:20], r[11:0]};
      h = {m[19:12], 12'h000};
      a = r[0] ? ((b & h) | (r[19:0] & ~h)) : r[19:0];
      {boot_base, boot_mask, mem_addr, mem_rd} <= {b, m, a, r[1]};
      @(posedge clock);
      #1 chk("boot select", !(r[1] && ((a ^ b) & h) == 20'h0), sel_n);
    end
    end_of_test();
  end
endmodule : srl_loader_test

// file: verif/srl_rom_model.sv
// Purpose: Behavioural three-wire serial memory with 8-bit word addresses
// Assumes: Released data line is pulled up, so it reads high when not driven
// Notes: Program time is a parameter; busy shows low while selected
`timescale 1ns/100ps
module srl_rom_model #(
  parameter int PROG_NS = 3000
) (
  input wire logic cs, // Chip select
  input wire logic sk, // Serial clock
  input wire logic di, // Data from device
  output logic dout // Data to device
);
  logic [15:0] mem [256];
  logic [26:0] sr;
  logic [10:0] hdr;
  logic [15:0] wd;
  logic [15:0] val;
  logic ew = 1'b0;
  logic drv = 1'b0;
  logic bv;
  logic prog;
  logic rdy = 1'b1;
  int cnt = 0;
  // Pull-up while deselected; ready status while selected and idle
  assign dout = !cs | (drv ? bv : rdy);
  // Shift in on the rising edge; a read answers a dummy zero, then 16 bits
  always @(posedge sk) if (cs) begin
    sr = {sr[25:0], di};
    cnt++;
    if (cnt == 11) hdr = sr[10:0];
    if (cnt == 27) wd = sr[15:0];
    drv = hdr[9:8] == 2'h2 && cnt >= 11 && cnt < 28;
    if (drv) bv = (cnt == 11) ? 1'b0 : mem[hdr[7:0]][27 - cnt];
  end
  // Programming starts at deselect, as a real part does
  always @(cs) begin
    if (!cs && cnt >= 11) begin
      prog = ew && (hdr[8] || hdr[9:6] == 4'h2 || hdr[9:6] == 4'h1);
      val = (hdr[9] || (!hdr[8] && hdr[7])) ? 16'hFFFF : wd;
      if (prog) begin
        for (int i = 0; i < 256; i++) if (!hdr[8] || i == hdr[7:0]) mem[i] = val;
        rdy = 1'b0;
        rdy <= #(PROG_NS) 1'b1;
      end
      if (hdr[9:6] == 4'h3) ew = 1'b1;
      if (hdr[9:6] == 4'h0) ew = 1'b0;
    end
    cnt = 0;
    drv = 1'b0;
  end
endmodule : srl_rom_model
